// *** flg_params.svh ***
// Constants for the fault latch and thermal guard
`ifndef FLG_PARAMS_SVH
`define FLG_PARAMS_SVH

`define FLG_CLK_MHZ          125
`define FLG_UPPER_BLANK_US   50
`define FLG_LOWER_BLANK_US   350
`define FLG_SS_US            4000
`define FLG_UPPER_CYC        (`FLG_UPPER_BLANK_US * `FLG_CLK_MHZ)
`define FLG_LOWER_CYC        (`FLG_LOWER_BLANK_US * `FLG_CLK_MHZ)
`define FLG_SS_CYC           (`FLG_SS_US * `FLG_CLK_MHZ)
`define FLG_CNT_W            20

`endif

// *** flg_pkg.sv ***
// Types for the fault latch and thermal guard
package flg_pkg;

  // Synchronised analog indications
  typedef struct packed {
    logic upper_trip;
    logic lower_trip;
    logic die_hot;
    logic supply_start;
    logic supply_reset;
  } flg_sense_t;

  // Protection outputs
  typedef struct packed {
    logic gate_drive_enable;
    logic high_voltage_startup_source;
    logic boosted_bias_current;
    logic latched_off;
    logic soft_start_active;
  } flg_ctrl_t;

  typedef enum logic [4:0] {
    FLG_WAIT    = 5'h01,
    FLG_SOFT    = 5'h02,
    FLG_RUN     = 5'h04,
    FLG_LATCHED = 5'h08,
    FLG_HOT     = 5'h10
  } flg_state_t;

endpackage : flg_pkg

// *** flg_deglitch.sv ***
// Persistence filter for one comparator output
`timescale 1ns/1ps
`include "flg_params.svh"

module flg_deglitch #(
  parameter logic [`FLG_CNT_W-1:0] LIMIT = 20'h00001
) (
  // Clock, reset and clock enable
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  // Qualified comparator and result
  input  wire logic i_enable,
  input  wire logic i_level,
  output logic      o_fired
);

  logic [`FLG_CNT_W-1:0] count;
  logic [`FLG_CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (!i_enable || !i_level) begin
      next_count = '0;                                        // R13
    end else if (count != LIMIT) begin
      next_count = count + 20'h00001;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= '0;
    end else if (i_ce) begin
      count <= next_count;
    end
  end

  // Longer than the blanking time: fires after LIMIT held cycles
  assign o_fired = i_enable && i_level && (count == LIMIT);

  deglitch_restart_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R13
    (i_ce && !i_level) |=> (count == '0))
    else $error("Deglitch count not cleared");

endmodule : flg_deglitch

// *** flg_guard.sv ***
// Fault latch and thermal guard sequencer
//
// Operation
// (R01) Run inside window, latch on either crossing
// (R02) Upper crossing latches after 50 us
// (R03) Lower crossing latches after 350 us
// (R04) Latched until supply reaches reset level
// (R05) Ignore comparators until ready to start
// (R06) Check upper trip before switching starts; code enables it only from FLG_SOFT, with drive already on
// (R07) Lower trip acts only after soft-start
// (R08) Doubled bias current during soft-start
// (R09) Die hot stops drive, disables source
// (R10) Die hot resets all controller state
// (R11) Hot clears: source on, restart sequence
// (R12) Soft-start on every start-level start
// (R13) Deglitch restarts when excursion ends
// (R14) Latched state holds drive off
`timescale 1ns/1ps
`include "flg_params.svh"

module flg_guard
  import flg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_ce,
  // Asynchronous analog indications
  input  wire flg_pkg::flg_sense_t i_sense,
  // Protection outputs
  output flg_pkg::flg_ctrl_t       o_ctrl,
  output flg_pkg::flg_state_t      o_state
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  flg_sense_t sync1;
  flg_sense_t sync2;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (i_ce) begin
      sync1 <= i_sense;
      sync2 <= sync1;
    end
  end

  // ---------------------------------------------------------------
  // Deglitch filters
  // ---------------------------------------------------------------
  flg_state_t state;
  flg_state_t next_state;
  logic       upper_fired;
  logic       lower_fired;
  logic       upper_en;
  logic       lower_en;

  assign upper_en = (state == FLG_SOFT) || (state == FLG_RUN);   // R05 R06
  assign lower_en = (state == FLG_RUN);                          // R07

  flg_deglitch #(
    .LIMIT (`FLG_CNT_W'(`FLG_UPPER_CYC))                         // R02
  ) u_upper (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_enable (upper_en),
    .i_level  (sync2.upper_trip),
    .o_fired  (upper_fired)
  );

  flg_deglitch #(
    .LIMIT (`FLG_CNT_W'(`FLG_LOWER_CYC))                         // R03
  ) u_lower (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_enable (lower_en),
    .i_level  (sync2.lower_trip),
    .o_fired  (lower_fired)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic [21:0] ss_count;
  logic [21:0] next_ss_count;

  always_comb begin
    next_state    = state;
    next_ss_count = ss_count;
    if (sync2.die_hot) begin
      next_state    = FLG_HOT;                                   // R09 R10
      next_ss_count = '0;
    end else begin
      unique case (state)
        FLG_HOT: begin
          next_state = FLG_WAIT;                                 // R11
        end
        FLG_WAIT: begin
          if (sync2.supply_start && !sync2.supply_reset) begin
            next_state    = FLG_SOFT;                            // R12
            next_ss_count = '0;
          end
        end
        FLG_SOFT: begin
          if (sync2.supply_reset) begin
            next_state = FLG_WAIT;
          end else if (upper_fired) begin
            next_state = FLG_LATCHED;                            // R01 R02
          end else if (ss_count == 22'(`FLG_SS_CYC - 1)) begin
            next_state = FLG_RUN;
          end else begin
            next_ss_count = ss_count + 22'h000001;
          end
        end
        FLG_RUN: begin
          if (sync2.supply_reset) begin
            next_state = FLG_WAIT;
          end else if (upper_fired || lower_fired) begin
            next_state = FLG_LATCHED;                            // R01
          end
        end
        FLG_LATCHED: begin
          if (sync2.supply_reset) begin
            next_state = FLG_WAIT;                               // R04
          end
        end
        default: begin
          next_state = FLG_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state    <= FLG_WAIT;
      ss_count <= '0;
    end else if (i_ce) begin
      state    <= next_state;
      ss_count <= next_ss_count;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  flg_ctrl_t ctrl;
  flg_ctrl_t next_ctrl;

  always_comb begin
    next_ctrl                              = '0;
    next_ctrl.gate_drive_enable            = (next_state == FLG_SOFT)
                                           || (next_state == FLG_RUN);  // R14 R09
    next_ctrl.high_voltage_startup_source  = (next_state != FLG_HOT);   // R09 R11
    next_ctrl.boosted_bias_current         = (next_state == FLG_SOFT);  // R08
    next_ctrl.soft_start_active            = (next_state == FLG_SOFT);
    next_ctrl.latched_off                  = (next_state == FLG_LATCHED);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= '0;
    end else if (i_ce) begin
      ctrl <= next_ctrl;
    end
  end

  assign o_ctrl  = ctrl;
  assign o_state = state;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence hot_seen;
    i_ce && sync2.die_hot;
  endsequence

  sequence hot_done;
    (state == FLG_HOT) ##1 (i_ce && !sync2.die_hot);
  endsequence

  hot_stop_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R09
    hot_seen |=> !o_ctrl.gate_drive_enable && !o_ctrl.high_voltage_startup_source)
    else $error("Drive or source active while hot");

  hot_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10
    hot_seen |=> (state == FLG_HOT) && (ss_count == '0))
    else $error("State not reset on die hot");

  hot_recover_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    (state == FLG_HOT) && i_ce && !sync2.die_hot |=>
      (state == FLG_WAIT) && o_ctrl.high_voltage_startup_source)
    else $error("No restart after hot clears");

  latch_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R04
    (state == FLG_LATCHED) && !sync2.supply_reset && !sync2.die_hot |=>
      (state == FLG_LATCHED))
    else $error("Latched state left without reset");

  latch_drive_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R14
    (state == FLG_LATCHED) && $past(state) == FLG_LATCHED |-> !o_ctrl.gate_drive_enable)
    else $error("Drive active while latched");

  boost_soft_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R08
    o_ctrl.boosted_bias_current == (state == FLG_SOFT))
    else $error("Bias current selection wrong");

  lower_mask_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R07
    (state == FLG_SOFT) |-> !lower_fired)
    else $error("Lower trip acted in soft-start");

  wait_mask_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R05
    (state == FLG_WAIT) && i_ce && !sync2.supply_start |=> (state != FLG_LATCHED))
    else $error("Latched before ready");

  start_soft_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
    (state == FLG_WAIT) && i_ce && sync2.supply_start && !sync2.supply_reset
      && !sync2.die_hot |=> (state == FLG_SOFT) ##0 o_ctrl.gate_drive_enable)
    else $error("Soft-start not entered");

  upper_latch_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R02
    upper_fired && i_ce && !sync2.die_hot && !sync2.supply_reset |=> (state == FLG_LATCHED))
    else $error("Upper trip did not latch");

  lower_latch_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R03
    lower_fired && i_ce && !sync2.die_hot && !sync2.supply_reset |=> (state == FLG_LATCHED))
    else $error("Lower trip did not latch");

  hot_cycle_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    hot_done |=> (state != FLG_HOT))
    else $error("Stuck in hot state");

endmodule : flg_guard

// *** flg_thermistor_net.sv ***
// Model of the thermistor and fault network on the latch pin
`timescale 1ns/1ps

module flg_thermistor_net #(
  parameter int CHARGE = 400
) (
  input  wire logic i_clk,
  input  wire logic i_boost,
  input  wire logic i_pull_up,
  input  wire logic thermistor_bias_current_hot,
  output logic      o_upper_trip,
  output logic      o_lower_trip
);
  int level = 0;

  // Pin capacitor starts low, charges twice as fast on boosted bias
  always @(posedge i_clk) begin
    if (level < CHARGE)
      level <= level + (i_boost ? 2 : 1);
  end

  assign o_upper_trip = i_pull_up;
  assign o_lower_trip = thermistor_bias_current_hot | (level < CHARGE);
endmodule : flg_thermistor_net

// *** testbench.sv ***
// Self-checking bench for the fault latch and thermal guard
`timescale 1ns/1ps

module testbench;
  import flg_pkg::*;
  logic       i_clk    = 1'b0;
  logic       i_resetn = 1'b0;
  logic       pull_up  = 1'b0;
  logic       ntc_hot  = 1'b0;
  logic       hot      = 1'b0;
  logic       sst      = 1'b0;
  logic       srst     = 1'b0;
  logic       ce       = 1'b1;
  logic       up;
  logic       lo;
  flg_sense_t sense;
  flg_ctrl_t  ctrl;
  flg_state_t state;
  int         errors   = 0;
  int         compares = 0;

  assign sense = {up, lo, hot, sst, srst};

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  flg_guard i_flg_guard (
    .i_clk   (i_clk),
    .i_resetn(i_resetn),
    .i_ce    (ce),
    .i_sense (sense),
    .o_ctrl  (ctrl),
    .o_state (state)
  );

  flg_thermistor_net i_flg_thermistor_net (
    .i_clk       (i_clk),
    .i_boost     (ctrl.boosted_bias_current),
    .i_pull_up   (pull_up),
    .thermistor_bias_current_hot   (ntc_hot),
    .o_upper_trip(up),
    .o_lower_trip(lo)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  // Compare state and the masked output bits
  task automatic chk(input flg_state_t st, input logic [4:0] exp, input logic [4:0] mask);
    compares++;
    if ((state !== st) || ((ctrl & mask) !== exp)) begin
      errors++;
      $display("wrong value at %0t: state %h ctrl %b", $time, state, ctrl);
    end
  endtask : chk

  task automatic wait_st(input flg_state_t st, input int n);
    int k;
    k = 0;
    while (state !== st && k < n) begin
      @(negedge i_clk);
      k++;
    end
    compares++;
    if (state !== st) begin
      errors++;
      $display("wrong value at %0t: state %h not reached", $time, state);
      end_of_test();
    end
  endtask : wait_st

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_wait_ignore();
    pull_up = 1'b1;
    ntc_hot = 1'b1;
    cyc(7000);
    chk(FLG_WAIT, 5'h08, 5'h1F);
    pull_up = 1'b0;
    ntc_hot = 1'b0;
    cyc(4);
  endtask : t_wait_ignore

  task automatic t_soft();
    sst = 1'b1;
    wait_st(FLG_SOFT, 6);
    chk(FLG_SOFT, 5'h15, 5'h17);
  endtask : t_soft

  task automatic t_upper();
    repeat (2) begin
      pull_up = 1'b1;
      cyc(6000);
      pull_up = 1'b0;
      cyc(4);
    end
    chk(FLG_SOFT, 5'h15, 5'h17);
    pull_up = 1'b1;
    cyc(6240);
    chk(FLG_SOFT, 5'h15, 5'h17);
    wait_st(FLG_LATCHED, 30);
    chk(FLG_LATCHED, 5'h02, 5'h17);
  endtask : t_upper

  task automatic t_latch_hold();
    pull_up = 1'b0;
    sst = 1'b0;
    cyc(50);
    sst = 1'b1;
    cyc(2000);
    chk(FLG_LATCHED, 5'h02, 5'h17);
    sst = 1'b0;
    srst = 1'b1;
    wait_st(FLG_WAIT, 6);
    srst = 1'b0;
    cyc(4);
  endtask : t_latch_hold

  task automatic t_lower_soft();
    ntc_hot = 1'b1;
    sst = 1'b1;
    wait_st(FLG_SOFT, 6);
    cyc(44000);
    chk(FLG_SOFT, 5'h15, 5'h17);
  endtask : t_lower_soft

  task automatic t_hot();
    hot = 1'b1;
    wait_st(FLG_HOT, 6);
    chk(FLG_HOT, 5'h00, 5'h18);
    ntc_hot = 1'b0;
    sst = 1'b0;
    cyc(20);
    hot = 1'b0;
    wait_st(FLG_WAIT, 6);
    chk(FLG_WAIT, 5'h08, 5'h1F);
    sst = 1'b1;
    wait_st(FLG_SOFT, 6);
  endtask : t_hot

  // Enable low freezes synchronisers and sequencer
  task automatic t_freeze();
    ce  = 1'b0;
    hot = 1'b1;
    cyc(10);
    chk(FLG_SOFT, 5'h15, 5'h17);
    ce = 1'b1;
    wait_st(FLG_HOT, 6);
    hot = 1'b0;
    cyc(4);
  endtask : t_freeze

  initial begin
    cyc(8);
    i_resetn = 1'b1;
    cyc(1);
    t_wait_ignore();
    t_soft();
    t_upper();
    t_latch_hold();
    t_lower_soft();
    t_hot();
    t_freeze();
    end_of_test();
  end
endmodule : testbench
